/* File: hdl/interrupt_vector_priority_unit.sv */
/*
 * interrupt vector priority unit: per-source sticky flags, local enables,
 * priority selection by vector address and a two-byte vector fetch port.
 * assumes the core masks requests with its global mask bit, stacks its
 * registers, then fetches the vector; peripherals clear flags by pulse.
 */
// Operation
// - higher vector address wins; reset vector has top priority
// - vector is two bytes: high byte at even address, low byte next
// - source event sets its flag regardless of local enable
// - request raised only while flag and local enable are both one; software and reset need only the flag
// - after stacking, core sets mask and fetches current winner's vector
// - vectors from lowest pair up to below display are unused
// - several pending when mask clears: highest priority serviced first
`timescale 1ns/1ps
`include "intc_defines.svh"

module interrupt_vector_priority_unit #(
   parameter int N = `NUM_SOURCES
) (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                rst_b,
   // peripheral side
   input  wire intc_pkg::src_vec_t  src_event,
   input  wire intc_pkg::src_vec_t  src_clear,
   input  wire intc_pkg::src_vec_t  src_enable,
   // core side
   input  wire logic                global_mask,
   output logic                     irq_pending,
   input  wire logic                vec_fetch_start,
   input  wire logic                vec_byte_req,
   output intc_pkg::vec_addr_t      vec_addr,
   output intc_pkg::byte_t          vec_byte,
   output logic                     vec_byte_valid,
   output intc_pkg::src_idx_t       vec_src,
   output intc_pkg::src_vec_t       flags,
   // vector table contents, one service address per source
   input  wire intc_pkg::vec_addr_t service_addr [`NUM_SOURCES]
);
   import intc_pkg::*;

   // elaboration checks: the map below assumes the full source set, with
   // display lowest and software and reset as the two highest sources
   if (N != `NUM_SOURCES) begin : g_bad_n
      $error("unit: N must match vector table size");
   end
   if ((1 << `SRC_IDX_W) < N) begin : g_bad_w
      $error("unit: source index too narrow for N");
   end
   if (`SRC_DISPLAY != 0) begin : g_bad_low
      $error("unit: display must be the lowest source");
   end
   if (`SRC_RESET != N - 1 || `SRC_SOFTWARE != N - 2) begin : g_bad_top
      $error("unit: reset and software must be the two highest sources");
   end
   if (`VEC_FIRST_USED + `VEC_STEP * (N - 1) != `VEC_TOP) begin : g_bad_map
      $error("unit: vector map must end at the reset vector");
   end
   if (`VEC_UNUSED_LO > `VEC_UNUSED_HI) begin : g_bad_gap
      $error("unit: unused vector space is empty");
   end
   if (`VEC_FIRST_USED != `VEC_UNUSED_HI + `VEC_STEP) begin : g_bad_first
      $error("unit: first used vector must follow the unused space");
   end

   src_vec_t     flag_r;
   src_vec_t     req;
   src_idx_t     sel_r;
   vec_addr_t    target_r;
   fetch_state_e state_r;
   logic         reset_fetch_r;
   prio_if       pif ();
   // winner and fetch strobes
   src_idx_t     win_now;
   logic         take_start;
   logic         take_high;
   logic         take_low;

   prio_encoder #(.N(N)) u_enc (
      .p (pif.enc)
   );

   // flags: set wins over clear so a same-cycle event is kept
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_src
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               flag_r[g] <= 1'b0;
            end else if (src_event[g]) begin
               flag_r[g] <= 1'b1;
            end else if (src_clear[g]) begin
               flag_r[g] <= 1'b0;
            end
         end
         // software and reset sources have no local enable; only reset also skips the global mask
         if (g == `SRC_SOFTWARE || g == `SRC_RESET) begin : g_nm
            assign req[g] = flag_r[g];
         end else begin : g_m
            assign req[g] = flag_r[g] & src_enable[g];
         end
      end
   endgenerate

   assign pif.req = req;
   assign flags   = flag_r;

   // reset vector ignores the global mask; others wait for the core
   assign irq_pending = pif.win_valid & (~global_mask | req[`SRC_RESET]);

   // map index to vector: display at first used pair, upward by two;
   // addresses below it never reach the core as a source
   function automatic vec_addr_t vector_of(input src_idx_t idx);
      vec_addr_t a;
      a = `VEC_FIRST_USED + vec_addr_t'({idx, 1'b0});
      return a;
   endfunction

   // the winner is frozen when the core starts the fetch, after stacking;
   // with nothing pending the core is running the software interrupt instruction
   assign take_start = vec_fetch_start && (state_r == FETCH_IDLE);
   assign win_now    = pif.win_valid ? pif.win_idx : `SRC_SOFTWARE;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sel_r    <= `SRC_RESET;
         target_r <= '0;
      end else if (take_start) begin
         sel_r    <= win_now;
         target_r <= service_addr[win_now];
      end
   end

   // until the first fetch the core is leaving reset, so the reset source is shown
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reset_fetch_r <= 1'b1;
      end else if (take_start) begin
         reset_fetch_r <= 1'b0;
      end
   end

   // fetch sequencer: high byte at even address, then low byte
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= FETCH_IDLE;
      end else begin
         case (state_r)
            FETCH_IDLE: begin
               if (vec_fetch_start) begin
                  state_r <= FETCH_HIGH;
               end
            end
            FETCH_HIGH: begin
               if (vec_byte_req) begin
                  state_r <= FETCH_LOW;
               end
            end
            FETCH_LOW: begin
               if (vec_byte_req) begin
                  state_r <= FETCH_IDLE;
               end
            end
            default: begin
               state_r <= FETCH_IDLE;
            end
         endcase
      end
   end

   // byte requests are taken only in the two fetch states; an idle request is refused
   assign take_high = vec_byte_req && (state_r == FETCH_HIGH);
   assign take_low  = vec_byte_req && (state_r == FETCH_LOW);

   // one-cycle strobe per accepted byte request
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         vec_byte_valid <= 1'b0;
      end else begin
         vec_byte_valid <= take_high | take_low;
      end
   end

   // address of the byte delivered: even half first, odd half next
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         vec_addr <= `VEC_TOP;
      end else if (take_high) begin
         vec_addr <= vector_of(sel_r);
      end else if (take_low) begin
         vec_addr <= vector_of(sel_r) + `VEC_LOW_BYTE;
      end
   end

   // byte delivered; it stands until the next accepted request
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         vec_byte <= '0;
      end else if (take_high) begin
         vec_byte <= target_r[15:8];
      end else if (take_low) begin
         vec_byte <= target_r[7:0];
      end
   end

   // source index shown to the core, one cycle behind the latched winner
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         vec_src <= `SRC_RESET;
      end else begin
         vec_src <= reset_fetch_r ? `SRC_RESET : sel_r;
      end
   end

   // stacking order and mask setting live in the core; this unit only
   // depends on the fetch starting after stacking
endmodule

/* File: pkg/intc_defines.svh */
/*
 * constants for the interrupt vector priority unit: vector addresses,
 * source indices and source count.
 * assumes inclusion by bare name; definitions only.
 */
`ifndef INTC_DEFINES_SVH
`define INTC_DEFINES_SVH

`define NUM_SOURCES        23
`define SRC_IDX_W          5
`define VEC_ADDR_W         16
`define VEC_TOP            16'hFFFE
`define VEC_UNUSED_LO      16'hFFC0
`define VEC_UNUSED_HI      16'hFFD0
`define VEC_FIRST_USED     16'hFFD2
`define VEC_STEP           16'h0002
`define VEC_LOW_BYTE       16'h0001
`define SRC_DISPLAY        5'h00
`define SRC_SOFTWARE       5'h15
`define SRC_RESET          5'h16

`endif

/* File: pkg/intc_pkg.sv */
/*
 * types shared by the interrupt vector priority unit and its priority encoder.
 * assumes intc_defines.svh is on the include path.
 */
`include "intc_defines.svh"

package intc_pkg;
   typedef logic [`NUM_SOURCES-1:0] src_vec_t;
   typedef logic [`SRC_IDX_W-1:0]   src_idx_t;
   typedef logic [`VEC_ADDR_W-1:0]  vec_addr_t;
   typedef logic [7:0]              byte_t;

   typedef enum logic [1:0] {
      FETCH_IDLE = 2'b00,
      FETCH_HIGH = 2'b01,
      FETCH_LOW  = 2'b10
   } fetch_state_e;
endpackage

/* File: pkg/prio_if.sv */
/*
 * carrier between the unit and its priority encoder: qualified requests in,
 * winning index and valid out.
 * assumes a single clock domain; purely combinational signals.
 */
`timescale 1ns/1ps

interface prio_if;
   import intc_pkg::*;
   src_vec_t  req;
   src_idx_t  win_idx;
   logic      win_valid;

   modport unit (output req, input win_idx, input win_valid);
   modport enc  (input req, output win_idx, output win_valid);
endinterface

/* File: hdl/prio_encoder.sv */
/*
 * fixed priority encoder: the highest set request index wins.
 * assumes index order follows vector address order, lowest address at index 0.
 */
`timescale 1ns/1ps
`include "intc_defines.svh"

module prio_encoder #(
   parameter int N = `NUM_SOURCES
) (
   // request side
   prio_if.enc  p
);
   import intc_pkg::*;

   // the carrier is sized for the full source set
   if (N != `NUM_SOURCES) begin : g_bad_n
      $error("prio_encoder: N must match source count");
   end

   // scanning upward lets the highest index overwrite lower ones
   always_comb begin
      p.win_idx   = '0;
      p.win_valid = 1'b0;
      for (int i = 0; i < N; i++) begin
         if (p.req[i]) begin
            p.win_idx   = src_idx_t'(i);
            p.win_valid = 1'b1;
         end
      end
   end
endmodule

/* File: bench/intc_assertions.sv */
/* port checker for the vector unit.
   assumes a bind from the bench top. */
`timescale 1ns/1ps
`include "intc_defines.svh"
module intc_assertions #(
   parameter int N = `NUM_SOURCES
) (
   // clock and reset
   input wire logic                clk,
   input wire logic                rst_b,
   // peripheral side
   input wire intc_pkg::src_vec_t  src_event,
   input wire intc_pkg::src_vec_t  src_enable,
   input wire intc_pkg::src_vec_t  flags,
   // core side
   input wire logic                global_mask,
   input wire logic                irq_pending,
   input wire logic                vec_fetch_start,
   input wire logic                vec_byte_req,
   input wire logic                vec_byte_valid,
   input wire intc_pkg::vec_addr_t vec_addr,
   input wire intc_pkg::byte_t     vec_byte,
   input wire intc_pkg::src_idx_t  vec_src,
   input wire intc_pkg::vec_addr_t service_addr [N]
);
   import intc_pkg::*;
   src_vec_t q;
   // software and reset sources ignore their local enable
   assign q = flags & (src_enable | 23'h60_0000);
   function automatic src_idx_t top(src_vec_t v);
      top = '0;
      for (int i = 0; i < N; i++) begin
         if (v[i]) top = i[4:0];
      end
   endfunction
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_flag_sets: assert property (|src_event |=> (flags & $past(src_event)) == $past(src_event))
      else $error("flag not set by event");
   a_no_request: assert property (irq_pending |-> |q)
      else $error("request without enabled flag");
   a_pend_shows: assert property (!global_mask && |q |-> irq_pending)
      else $error("qualified request not raised");
   a_mask_blocks: assert property (global_mask && !flags[22] |-> !irq_pending)
      else $error("request passed the mask");
   a_winner_high: assert property (vec_fetch_start && |q |-> ##2 vec_src == top($past(q, 2)))
      else $error("winner not highest");
   a_high_byte: assert property (vec_byte_valid && !vec_addr[0] |-> vec_byte == service_addr[vec_src][15:8])
      else $error("high byte wrong");
   a_low_byte: assert property (vec_byte_valid && vec_addr[0] |-> vec_byte == service_addr[vec_src][7:0])
      else $error("low byte wrong");
   a_byte_order: assert property (vec_byte_valid && !vec_addr[0] ##1 vec_byte_valid |-> vec_addr == $past(vec_addr) + 16'h0001)
      else $error("low byte not next address");
   a_vec_map: assert property (vec_byte_valid |-> {vec_addr[15:1], 1'b0} == 16'hFFD2 + {10'h0, vec_src, 1'b0})
      else $error("vector pair mismatch");
   a_unused_free: assert property (vec_byte_valid |-> vec_addr >= 16'hFFD2 && $past(vec_byte_req))
      else $error("unused vector or unrequested byte");
   c_entry: cover property (vec_fetch_start && |q);
   c_two: cover property (vec_fetch_start && $countones(q) > 1);
   c_low: cover property (vec_byte_valid && vec_addr[0]);
endmodule

/* File: bench/core_model.sv */
/* behavioural core: mask bit, stacking delay, two-byte vector fetch.
   assumes the unit answers each byte request one cycle later. */
`timescale 1ns/1ps
module core_model (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                rst_b,
   // unit side
   input  wire logic                irq_pending,
   input  wire logic                vec_byte_valid,
   input  wire intc_pkg::vec_addr_t vec_addr,
   input  wire intc_pkg::byte_t     vec_byte,
   output logic                     global_mask,
   output logic                     vec_fetch_start,
   output logic                     vec_byte_req,
   // bench side
   input  wire logic                allow,
   output logic                     done,
   output intc_pkg::vec_addr_t      svc
);
   import intc_pkg::*;
   logic [3:0] st_r;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         global_mask <= 1'b1;
         st_r <= '0;
         vec_fetch_start <= 1'b0;
         vec_byte_req <= 1'b0;
      end else begin
         vec_fetch_start <= 1'b0;
         vec_byte_req <= 1'b0;
         if (allow && st_r == 4'h0) global_mask <= 1'b0;
         if (st_r == 4'h0 && !global_mask && irq_pending) st_r <= 4'h1;
         else if (st_r != 4'h0 && st_r < 4'h6) st_r <= st_r + 4'h1; // five pushes
         else if (st_r == 4'h6) begin
            global_mask <= 1'b1;
            vec_fetch_start <= 1'b1;
            st_r <= 4'h7;
         end else if (st_r == 4'h7 || st_r == 4'h8) begin
            vec_byte_req <= 1'b1;
            st_r <= st_r + 4'h1;
         end else if (st_r == 4'h9 && done) st_r <= 4'h0;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         svc <= '0;
         done <= 1'b0;
      end else begin
         done <= vec_byte_valid && vec_addr[0];
         if (vec_byte_valid && !vec_addr[0]) svc[15:8] <= vec_byte;
         if (vec_byte_valid && vec_addr[0]) svc[7:0] <= vec_byte;
      end
   end
endmodule

/* File: bench/interrupt_vector_priority_unit_test.sv */
/* self-checking bench for the vector unit with a core model.
   assumes the design package and interface are compiled first. */
`timescale 1ns/1ps
`define CHECK_EQ(nm, e, s) begin num_checks++; if ((s) !== (e)) begin failures++; \
   $display("wrong value %s expected %h seen %h", nm, e, s); end end
module interrupt_vector_priority_unit_test;
   import intc_pkg::*;
   logic clk, rst_b, global_mask, irq_pending, vec_fetch_start, vec_byte_req, vec_byte_valid, allow, done;
   src_vec_t src_event, src_clear, src_enable, flags;
   vec_addr_t service_addr [23];
   vec_addr_t vec_addr, svc;
   byte_t vec_byte;
   src_idx_t vec_src, idx, exp_q[$];
   int failures = 0, num_checks = 0, cycles = 0, a, b;
   logic [31:0] seed = 32'h0000_4c68, r;
   interrupt_vector_priority_unit dut_u (.clk, .rst_b, .src_event, .src_clear, .src_enable, .global_mask,
      .irq_pending, .vec_fetch_start, .vec_byte_req, .vec_addr, .vec_byte, .vec_byte_valid, .vec_src, .flags,
      .service_addr);
   core_model core_u (.clk, .rst_b, .irq_pending, .vec_byte_valid, .vec_addr, .vec_byte, .global_mask,
      .vec_fetch_start, .vec_byte_req, .allow, .done, .svc);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic stop_test();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wait_done();
      do @(negedge clk); while (done !== 1'b1);
   endtask
   // the core model drops its mask only while idle, so allow stands until it has
   task automatic open_mask();
      allow = 1;
      do @(negedge clk); while (global_mask !== 1'b0);
      allow = 0;
   endtask
   task automatic serve(input int s);
      wait_done();
      src_clear[s] = 1;
      open_mask();
      src_clear = '0;
   endtask
   initial begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         stop_test();
      end
   end
   always @(negedge clk) begin
      if (done === 1'b1) begin
         idx = exp_q.pop_front();
         `CHECK_EQ("service", service_addr[idx], svc)
         `CHECK_EQ("vector", 16'hFFD3 + {10'h0, idx, 1'b0}, vec_addr)
      end
   end
   initial begin
      {src_event, src_clear, src_enable, allow, rst_b} = '0;
      for (int i = 0; i < 23; i++) service_addr[i] = vec_addr_t'(rnd());
      repeat (20) @(posedge clk);
      @(negedge clk) rst_b = 1;
      for (int k = 0; k < 12; k++) begin
         r = rnd();
         a = int'(r % 20);
         b = a + 1 + int'((r >> 8) % (20 - a));
         src_event[a] = 1;
         src_event[b] = 1;
         @(negedge clk) src_event = '0;
         `CHECK_EQ("flags", 2'b11, {flags[b], flags[a]})
         `CHECK_EQ("irq_pending", 1'b0, irq_pending)
         exp_q.push_back(src_idx_t'(b));
         exp_q.push_back(src_idx_t'(a));
         src_enable[a] = 1;
         src_enable[b] = 1;
         open_mask();
         serve(b); // lower source still pending under the mask
         serve(a);
         @(negedge clk) src_enable = '0;
      end
      // reset and software need no local enable; reset outranks all
      src_event[22] = 1;
      src_event[21] = 1;
      src_event[3] = 1;
      @(negedge clk) src_event = '0;
      `CHECK_EQ("flags", 3'b111, {flags[22], flags[21], flags[3]})
      `CHECK_EQ("irq_pending", 1'b1, irq_pending)
      src_enable[3] = 1;
      exp_q.push_back(5'h16);
      exp_q.push_back(5'h15);
      exp_q.push_back(5'h03);
      serve(22);
      serve(21);
      serve(3);
      stop_test();
   end
endmodule
bind interrupt_vector_priority_unit intc_assertions #(.N(N)) chk_u (.clk, .rst_b, .src_event, .src_enable, .flags,
   .global_mask, .irq_pending, .vec_fetch_start, .vec_byte_req, .vec_byte_valid, .vec_addr, .vec_byte, .vec_src,
   .service_addr);
